//--- logic/twr_pkg.sv
package twr_pkg;

	// system clock, 20 MHz
	localparam int CLK_PERIOD_NS = 50;

	// register map of the serial port (7-bit addresses)
	localparam logic [6:0] REG_CTRL = 7'h0b;
	localparam logic [6:0] REG_STATUS = 7'h0c;
	localparam logic [6:0] REG_WDOG = 7'h0d;
	localparam logic [6:0] REG_ADC = 7'h0e;
	localparam int GEN_REGS = 11;

	// control register fields
	localparam int CTRL_OSC_OFF_BIT = 7;
	localparam int CTRL_WP_BIT = 6;
	localparam int CTRL_CHAN_LSB = 4;
	localparam logic [7:0] CTRL_RESET = 8'h80;
	// status register fields
	localparam int STAT_PENDING_BIT = 7;
	// watchdog register fields
	localparam logic [7:0] WDOG_RESET = 8'h03;
	localparam logic [7:0] WDOG_MASK = 8'h03;
	localparam logic [1:0] WD_OFF = 2'h0;
	localparam logic [1:0] WD_SEL_250 = 2'h1;
	localparam logic [1:0] WD_SEL_500 = 2'h2;
	localparam logic [9:0] WD_250_MS = 10'd250;
	localparam logic [9:0] WD_500_MS = 10'd500;
	localparam logic [9:0] WD_1000_MS = 10'd1000;

	// channel-select codes
	localparam logic [1:0] CHAN_NONE = 2'h0;
	localparam logic [1:0] CHAN_ZERO = 2'h1;
	localparam logic [1:0] CHAN_ONE = 2'h2;

	// command byte: bit 7 is read(0)/write(1)
	localparam int CMD_RW_BIT = 7;

	// adc timing: flag leads the update, update repeats each period
	localparam int ADC_LEAD_US = 300;
	localparam int ADC_PERIOD_MS = 10;
	localparam int ADC_LEAD_CYC = (ADC_LEAD_US * 1000) / CLK_PERIOD_NS;
	localparam int ADC_PERIOD_CYC = (ADC_PERIOD_MS * 1000000) / CLK_PERIOD_NS;
	localparam int ADC_WAIT_CYC = ADC_PERIOD_CYC - ADC_LEAD_CYC;

	// host link timing
	localparam int SCLK_HALF_NS = 300;
	localparam int CS_SETUP_NS = 1000;
	localparam int CS_GAP_NS = 1000;
	localparam int SCLK_HALF_CYC = (SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CS_SETUP_CYC = (CS_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CS_GAP_CYC = (CS_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// host apb register map
	localparam logic [7:0] HOST_CTRL = 8'h00;
	localparam logic [7:0] HOST_WDATA = 8'h04;
	localparam logic [7:0] HOST_STATUS = 8'h08;
	localparam logic [7:0] HOST_RDATA = 8'h0c;
	localparam int HCTRL_LEN_LSB = 8;
	localparam int HCTRL_GO_BIT = 16;
	localparam logic [2:0] HOST_MAX_LEN = 3'd4;

endpackage

//--- logic/twr_link_if.sv
`timescale 1ns/1ps
interface twr_link_if;
	logic cs;
	logic sclk;
	logic host_out;
	logic host_oe;
	logic dev_out;
	logic dev_oe;
	logic io;

	// resolved data line; an undriven line reads low
	assign io = host_oe ? host_out : (dev_oe ? dev_out : 1'b0);

	modport dev (input cs, input sclk, input io, output dev_out, output dev_oe);
	modport host (output cs, output sclk, output host_out, output host_oe,
		input io);
endinterface

//--- logic/twr_device.sv
`timescale 1ns/1ps
// Behaviour
// - watchdog field decodes off, 250, 500, 1000 ms
// - result is 8-bit code, ground 00h, ref FFh
// - first result within 488us of enabling
// - channel none turns converter off
// - result refreshes about every 10 ms
// - channel change applies at next periodic slot
// - pending flag leads update, clear means quiet
// - host polls pending flag before reading result
// - result update deferred during its serial read
// - chip select low aborts read, frees update
// - chip select high starts every transfer
// - chip select low ends transfer, releases line
// - sample on rising edge, drive on falling
// - bytes shift least significant bit first
// - first byte is command, top bit write
// - single access is one byte then deselect
// - address increments after every data byte
// - address wraps from 0Eh to 00h
// - channel codes none, input zero, one, two
// - write protect blocks every serial write
// - result lives at 0Eh, flag concerns it
// - watchdog bits set, channel bits clear at reset
module twr_device
	import twr_pkg::*;
	#(
	parameter int unsigned LEAD_CYC = ADC_LEAD_CYC,
	parameter int unsigned WAIT_CYC = ADC_WAIT_CYC
	)
	(
	// clock and reset
	input wire logic sys_clk,
	input wire logic rstn,
	// serial link
	twr_link_if.dev link,
	// converter inputs, already quantised
	input wire logic [7:0] analog_in_zero,
	input wire logic [7:0] analog_in_one,
	input wire logic [7:0] analog_in_two,
	// watchdog setting towards the watchdog counter
	output logic wd_enable,
	output logic [9:0] wd_timeout_ms,
	// converter state
	output logic [1:0] adc_channel,
	output logic update_pending_flag
	);

	typedef enum logic [1:0] {ADC_OFF, ADC_LEAD, ADC_WAIT} twr_adc_type;

	// watchdog select to time-out in ms
	function automatic logic [9:0] wd_ms(input logic [1:0] sel);
		if (sel == WD_OFF) begin
			return 10'd0;
		end else if (sel == WD_SEL_250) begin
			return WD_250_MS;
		end else if (sel == WD_SEL_500) begin
			return WD_500_MS;
		end
		return WD_1000_MS;
	endfunction

	// burst address step with wrap after the result register
	function automatic logic [6:0] next_addr(input logic [6:0] a);
		return (a >= REG_ADC) ? 7'h00 : a + 7'h01;
	endfunction

	logic [1:0] cs_sync;
	logic [1:0] sclk_sync;
	logic [1:0] io_sync;
	logic sclk_prev;
	logic cmd_phase;
	logic rd_mode;
	logic [2:0] bit_cnt;
	logic [7:0] shin;
	logic [7:0] shout;
	logic [6:0] addr;
	logic io_out;
	logic io_oe;
	logic [7:0] ctrl;
	logic [7:0] wdog;
	logic [7:0] gen_reg [0:GEN_REGS-1];
	logic [7:0] adc_result;
	twr_adc_type adc_state;
	logic [17:0] adc_cnt;
	logic [1:0] conv_chan;

	// link decode
	wire cs_s = cs_sync[1];
	wire rise = cs_s & sclk_sync[1] & ~sclk_prev;
	wire fall = cs_s & ~sclk_sync[1] & sclk_prev;
	wire [7:0] byte_in = {io_sync[1], shin[7:1]};
	wire byte_done = rise && (bit_cnt == 3'd7);
	wire [6:0] cmd_addr = byte_in[6:0];
	wire cmd_read = ~byte_in[CMD_RW_BIT];
	wire [6:0] load_addr = cmd_phase ? cmd_addr : next_addr(addr);
	wire [7:0] status = {update_pending_flag, 7'h00};
	wire [7:0] rd_val = (load_addr < REG_CTRL) ? gen_reg[load_addr[3:0]] :
		(load_addr == REG_CTRL) ? ctrl :
		(load_addr == REG_STATUS) ? status :
		(load_addr == REG_WDOG) ? wdog :
		(load_addr == REG_ADC) ? adc_result : 8'h00;
	wire wr_en = byte_done && !cmd_phase && !rd_mode &&
		!ctrl[CTRL_WP_BIT];
	wire read_hold = cs_s && rd_mode && (addr == REG_ADC);
	wire [1:0] ch_sel = ctrl[CTRL_CHAN_LSB +: 2];
	wire [7:0] sample = (conv_chan == CHAN_ZERO) ? analog_in_zero :
		(conv_chan == CHAN_ONE) ? analog_in_one : analog_in_two;

	assign link.dev_out = io_out;
	assign link.dev_oe = io_oe;

	// pins come from the host's domain: two flops before use
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			cs_sync <= 2'b00;
			sclk_sync <= 2'b00;
			io_sync <= 2'b00;
			sclk_prev <= 1'b0;
		end else begin
			cs_sync <= {cs_sync[0], link.cs};
			sclk_sync <= {sclk_sync[0], link.sclk};
			io_sync <= {io_sync[0], link.io};
			sclk_prev <= sclk_sync[1];
		end
	end

	// serial shifter; deselect wins over any edge in flight
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			cmd_phase <= 1'b1;
			rd_mode <= 1'b0;
			bit_cnt <= 3'd0;
			shin <= 8'h00;
			shout <= 8'h00;
			addr <= 7'h00;
			io_out <= 1'b0;
			io_oe <= 1'b0;
		end else if (!cs_s) begin
			cmd_phase <= 1'b1;
			rd_mode <= 1'b0;
			bit_cnt <= 3'd0;
			io_oe <= 1'b0;
		end else begin
			if (rise) begin
				shin <= byte_in;
				bit_cnt <= bit_cnt + 3'd1;
			end
			if (byte_done) begin
				cmd_phase <= 1'b0;
				addr <= load_addr;
				if (cmd_phase) begin
					rd_mode <= cmd_read;
				end
				if ((cmd_phase && cmd_read) || (!cmd_phase && rd_mode)) begin
					shout <= rd_val;
				end
			end
			if (fall && rd_mode) begin
				io_out <= shout[0];
				shout <= {1'b0, shout[7:1]};
				io_oe <= 1'b1;
			end
		end
	end

	// software-visible registers, written from the link
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			ctrl <= CTRL_RESET;
			wdog <= WDOG_RESET;
			for (int i = 0; i < GEN_REGS; i++) begin
				gen_reg[i] <= 8'h00;
			end
		end else if (wr_en) begin
			if (addr < REG_CTRL) begin
				gen_reg[addr[3:0]] <= byte_in;
			end else if (addr == REG_CTRL) begin
				ctrl <= byte_in;
			end else if (addr == REG_WDOG) begin
				wdog <= byte_in & WDOG_MASK;
			end
		end
	end

	// watchdog setting handed on as a decoded time-out
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			wd_enable <= 1'b1;
			wd_timeout_ms <= WD_1000_MS;
		end else begin
			wd_enable <= (wdog[1:0] != WD_OFF);
			wd_timeout_ms <= wd_ms(wdog[1:0]);
		end
	end

	// conversion sequencer: flag goes up a lead time before each update;
	// a held read stretches the lead, so the flag stays up meanwhile
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			adc_state <= ADC_OFF;
			adc_cnt <= 18'd0;
			conv_chan <= CHAN_NONE;
			adc_result <= 8'h00;
			update_pending_flag <= 1'b0;
		end else if (ch_sel == CHAN_NONE) begin
			adc_state <= ADC_OFF;
			update_pending_flag <= 1'b0;
			adc_cnt <= 18'd0;
		end else begin
			unique case (adc_state)
				ADC_OFF: begin
					adc_state <= ADC_LEAD;
					conv_chan <= ch_sel;
					adc_cnt <= 18'd0;
					update_pending_flag <= 1'b1;
				end
				ADC_LEAD: begin
					if (adc_cnt >= 18'(LEAD_CYC - 1)) begin
						if (!read_hold) begin
							adc_result <= sample;
							update_pending_flag <= 1'b0;
							adc_state <= ADC_WAIT;
							adc_cnt <= 18'd0;
						end
					end else begin
						adc_cnt <= adc_cnt + 18'd1;
					end
				end
				ADC_WAIT: begin
					if (adc_cnt >= 18'(WAIT_CYC - 1)) begin
						adc_state <= ADC_LEAD;
						conv_chan <= ch_sel;
						adc_cnt <= 18'd0;
						update_pending_flag <= 1'b1;
					end else begin
						adc_cnt <= adc_cnt + 18'd1;
					end
				end
				// the fourth code is never entered; recover to off
				default: begin
					adc_state <= ADC_OFF;
				end
			endcase
		end
	end

	// channel actually in use, for observation
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			adc_channel <= CHAN_NONE;
		end else begin
			adc_channel <= (adc_state == ADC_OFF) ? CHAN_NONE : conv_chan;
		end
	end

endmodule

//--- logic/twr_host.sv
`timescale 1ns/1ps
module twr_host
	import twr_pkg::*;
	(
	// clock and reset
	input wire logic sys_clk,
	input wire logic rstn,
	// apb slave
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// serial link
	twr_link_if.host link
	);

	typedef enum logic [2:0] {
		H_IDLE, H_SETUP, H_LOW, H_HIGH, H_HOLD, H_GAP
	} twr_host_type;

	twr_host_type state;
	logic [7:0] cmd;
	logic [2:0] len;
	logic [31:0] wdata;
	logic [31:0] rdata;
	logic busy;
	logic [39:0] tx;
	logic [5:0] bit_idx;
	logic [4:0] cnt;
	logic [1:0] io_sync;
	logic cs;
	logic sclk;
	logic io_out;
	logic io_oe;

	// apb decode
	wire setup = psel & ~penable;
	wire access = psel & penable & pready;
	wire mapped = (paddr == HOST_CTRL) || (paddr == HOST_WDATA) ||
		(paddr == HOST_STATUS) || (paddr == HOST_RDATA);
	wire [31:0] rd_mux = (paddr == HOST_CTRL) ?
		{21'h0, len, cmd} :
		(paddr == HOST_WDATA) ? wdata :
		(paddr == HOST_STATUS) ? {31'h0, busy} :
		(paddr == HOST_RDATA) ? rdata : 32'h0;
	wire [2:0] new_len = pwdata[HCTRL_LEN_LSB +: 3];
	wire start = access && pwrite && (paddr == HOST_CTRL) && !busy &&
		pwdata[HCTRL_GO_BIT] && (new_len != 3'd0) &&
		(new_len <= HOST_MAX_LEN);
	// link decode
	wire is_write = tx[CMD_RW_BIT];
	wire [5:0] last_bit = {len, 3'b111};
	wire [5:0] nxt_idx = bit_idx + 6'd1;
	wire half_done = (cnt == 5'(SCLK_HALF_CYC - 1));

	assign link.cs = cs;
	assign link.sclk = sclk;
	assign link.host_out = io_out;
	assign link.host_oe = io_oe;

	// one wait-free access: answer prepared in the setup cycle
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0;
		end else begin
			pready <= setup;
			pslverr <= setup & ~mapped;
			prdata <= (setup && !pwrite) ? rd_mux : 32'h0;
		end
	end

	// orders are refused while a transfer runs
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			cmd <= 8'h00;
			len <= 3'd1;
			wdata <= 32'h0;
		end else if (access && pwrite && !busy) begin
			if (paddr == HOST_CTRL) begin
				cmd <= pwdata[7:0];
				len <= new_len;
			end else if (paddr == HOST_WDATA) begin
				wdata <= pwdata;
			end
		end
	end

	// the data line is read late in the high phase, well after the
	// device has driven it on the previous falling edge
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			io_sync <= 2'b00;
		end else begin
			io_sync <= {io_sync[0], link.io};
		end
	end

	// link engine
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			state <= H_IDLE;
			busy <= 1'b0;
			cs <= 1'b0;
			sclk <= 1'b0;
			io_out <= 1'b0;
			io_oe <= 1'b0;
			tx <= 40'h0;
			rdata <= 32'h0;
			bit_idx <= 6'd0;
			cnt <= 5'd0;
		end else begin
			unique case (state)
				H_IDLE: begin
					if (start) begin
						cs <= 1'b1;
						busy <= 1'b1;
						tx <= {wdata, pwdata[7:0]};
						rdata <= 32'h0;
						bit_idx <= 6'd0;
						cnt <= 5'd0;
						state <= H_SETUP;
					end
				end
				H_SETUP: begin
					if (cnt == 5'(CS_SETUP_CYC - 1)) begin
						io_out <= tx[0];
						io_oe <= 1'b1;
						cnt <= 5'd0;
						state <= H_LOW;
					end else begin
						cnt <= cnt + 5'd1;
					end
				end
				H_LOW: begin
					if (half_done) begin
						sclk <= 1'b1;
						cnt <= 5'd0;
						state <= H_HIGH;
					end else begin
						cnt <= cnt + 5'd1;
					end
				end
				H_HIGH: begin
					if (half_done) begin
						sclk <= 1'b0;
						cnt <= 5'd0;
						bit_idx <= nxt_idx;
						if (!is_write && bit_idx[5:3] != 3'd0) begin
							rdata[5'(bit_idx - 6'd8)] <= io_sync[1];
						end
						if (bit_idx == last_bit) begin
							io_oe <= 1'b0;
							state <= H_HOLD;
						end else begin
							io_out <= tx[nxt_idx];
							io_oe <= (nxt_idx[5:3] == 3'd0) || is_write;
							state <= H_LOW;
						end
					end else begin
						cnt <= cnt + 5'd1;
					end
				end
				H_HOLD: begin
					cs <= 1'b0;
					state <= H_GAP;
				end
				H_GAP: begin
					if (cnt == 5'(CS_GAP_CYC - 1)) begin
						busy <= 1'b0;
						cnt <= 5'd0;
						state <= H_IDLE;
					end else begin
						cnt <= cnt + 5'd1;
					end
				end
				default: begin
					state <= H_IDLE;
				end
			endcase
		end
	end

endmodule

//--- bench/twr_link_checker.sv
`timescale 1ns/1ps
module twr_link_checker (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rstn,
	// link signals
	input wire logic cs,
	input wire logic sclk,
	input wire logic host_out,
	input wire logic host_oe,
	input wire logic dev_out,
	input wire logic dev_oe,
	input wire logic io
	);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rstn);
	// line handling around deselect
	a_release_deselect: assert property ($fell(cs) |-> ##[0:5] !dev_oe)
		else $error("line held after deselect");
	a_idle_quiet: assert property (!cs [*6] |-> !dev_oe)
		else $error("device drives while idle");
	a_one_driver: assert property (!(host_oe && dev_oe))
		else $error("both ends drive the line");
	// edge discipline: device moves in low phase, host holds in high
	a_dev_edge: assert property (dev_oe && $past(dev_oe)
		&& $changed(dev_out) |-> !sclk)
		else $error("device data moved in high phase");
	a_host_steady: assert property (sclk && $past(sclk)
		|-> $stable(host_out))
		else $error("host data moved in high phase");
	// framing of the serial clock by chip select
	a_sclk_framed: assert property (sclk |-> cs)
		else $error("serial clock outside frame");
	a_cs_setup: assert property ($rose(cs) |-> !sclk [*8])
		else $error("clock too soon after select");
	a_cs_gap: assert property ($fell(cs) |-> !cs [*8])
		else $error("deselect gap too short");
	a_read_start: assert property ($rose(dev_oe) |-> cs && !sclk)
		else $error("read data started badly");
	c_read: cover property ($rose(dev_oe));
	c_write: cover property ($rose(host_oe));
	c_frame_end: cover property ($fell(cs) ##1 !cs [*3]);
endmodule

//--- bench/three_wire_reg_port_adc_ctrl_tb_top.sv
`timescale 1ns/1ps
module three_wire_reg_port_adc_ctrl_tb_top
	import twr_pkg::*;
	();
	// shortened converter timing keeps the run brief
	localparam int LEAD = 40;
	localparam int WAITC = 200;
	logic sys_clk = 1'b0;
	logic rstn = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic perr;
	logic [31:0] rd;
	logic [7:0] in_z = 8'h5c;
	logic [7:0] in_o = 8'hff;
	logic [7:0] in_t = 8'h00;
	logic wd_enable;
	logic [9:0] wd_timeout_ms;
	logic [1:0] adc_channel;
	logic update_pending_flag;
	int failures = 0;
	int check_count = 0;
	int flag_run = 0;
	int flag_max = 0;
	int unsigned wdms [4] = '{0, 250, 500, 1000};
	twr_link_if twr_link_if_i ();
	twr_host twr_host_i (.sys_clk(sys_clk), .rstn(rstn), .paddr(paddr),
		.psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.link(twr_link_if_i));
	twr_device #(.LEAD_CYC(LEAD), .WAIT_CYC(WAITC)) twr_device_i (
		.sys_clk(sys_clk), .rstn(rstn), .link(twr_link_if_i),
		.analog_in_zero(in_z), .analog_in_one(in_o), .analog_in_two(in_t),
		.wd_enable(wd_enable), .wd_timeout_ms(wd_timeout_ms),
		.adc_channel(adc_channel), .update_pending_flag(update_pending_flag));
	twr_link_checker twr_link_checker_i (.sys_clk(sys_clk), .rstn(rstn),
		.cs(twr_link_if_i.cs), .sclk(twr_link_if_i.sclk),
		.host_out(twr_link_if_i.host_out), .host_oe(twr_link_if_i.host_oe),
		.dev_out(twr_link_if_i.dev_out), .dev_oe(twr_link_if_i.dev_oe),
		.io(twr_link_if_i.io));
	initial begin
		forever #25 sys_clk = ~sys_clk;
	end
	// longest stretch of the pending flag; only a held update exceeds lead
	always @(posedge sys_clk) begin
		flag_run <= update_pending_flag ? flag_run + 1 : 0;
		if (flag_run > flag_max) begin
			flag_max <= flag_run;
		end
	end
	task automatic finish_test;
		$display("checks=%0d failures=%0d", check_count, failures);
		if (failures == 0 && check_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			failures++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// one apb transfer; answer taken at the edge where pready is high
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge sys_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		@(posedge sys_clk);
		while (pready !== 1'b1) begin
			@(posedge sys_clk);
		end
		rd = prdata;
		perr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// whole serial frame: command byte plus n data bytes
	task automatic xfer(input logic [7:0] cmd, input logic [2:0] n,
		input logic [31:0] wd);
		int k;
		k = 0;
		apb(1'b1, HOST_WDATA, wd);
		apb(1'b1, HOST_CTRL, {15'h0, 1'b1, 5'h0, n, cmd});
		do begin
			apb(1'b0, HOST_STATUS, 32'h0);
			k++;
		end while (rd[0] !== 1'b0 && k < 4000);
		chk({31'h0, rd[0]}, 32'h0);
		apb(1'b0, HOST_RDATA, 32'h0);
	endtask
	// bounded wait for the pending flag, cycles spent in n
	task automatic wait_flag(input logic v, output int n);
		n = 0;
		@(negedge sys_clk);
		while (update_pending_flag !== v && n < 1000) begin
			@(negedge sys_clk);
			n++;
		end
		chk({31'h0, update_pending_flag}, {31'h0, v});
	endtask
	initial begin
		int k;
		repeat (3) @(posedge sys_clk);
		rstn <= 1'b1;
		#1;
		chk({22'h0, wd_timeout_ms}, 32'd1000);
		chk({31'h0, wd_enable}, 32'h1);
		chk({30'h0, adc_channel}, 32'h0);
		xfer({1'b0, REG_CTRL}, 3'd1, 32'h0);
		chk({24'h0, rd[7:0]}, {24'h0, CTRL_RESET});
		apb(1'b0, 8'h10, 32'h0);
		chk({31'h0, perr}, 32'h1);
		$display("test reset done");
		for (int v = 0; v < 4; v++) begin
			xfer({1'b1, REG_WDOG}, 3'd1, v);
			xfer({1'b0, REG_WDOG}, 3'd1, 32'h0);
			chk({24'h0, rd[7:0]}, v);
			chk({22'h0, wd_timeout_ms}, wdms[v]);
			chk({31'h0, wd_enable}, {31'h0, v != 0});
		end
		$display("test watchdog done");
		// burst across the wrap; the result byte is not writable
		xfer({1'b1, REG_WDOG}, 3'd4, 32'h3412_9903);
		xfer({1'b0, REG_WDOG}, 3'd4, 32'h0);
		chk(rd, 32'h3412_0003);
		$display("test burst done");
		for (int c = 1; c < 4; c++) begin
			xfer({1'b1, REG_CTRL}, 3'd1, c << CTRL_CHAN_LSB);
			if (c > 1) chk({30'h0, adc_channel}, c - 1);
			wait_flag(1'b1, k);
			@(negedge sys_clk); // channel output trails the flag a cycle
			chk({30'h0, adc_channel}, c);
			wait_flag(1'b0, k);
			chk({31'h0, k <= LEAD + 3}, 32'h1);
			// poll the status byte before touching the result
			xfer({1'b0, REG_STATUS}, 3'd1, 32'h0);
			chk({24'h0, rd[7:0]}, 32'h0);
			xfer({1'b0, REG_ADC}, 3'd1, 32'h0);
			chk({24'h0, rd[7:0]},
				{24'h0, c == 1 ? in_z : (c == 2 ? in_o : in_t)});
			wait_flag(1'b1, k);
			wait_flag(1'b0, k);
		end
		$display("test converter done");
		// read timed so the hold spans the due update; flag stays up
		repeat (72) @(posedge sys_clk);
		xfer({1'b0, REG_ADC}, 3'd1, 32'h0);
		chk({24'h0, rd[7:0]}, {24'h0, in_t});
		chk({31'h0, flag_max > LEAD + 20}, 32'h1);
		wait_flag(1'b0, k);
		$display("test read hold done");
		xfer({1'b1, REG_CTRL}, 3'd1, 32'h0);
		chk({30'h0, adc_channel}, 32'h0);
		k = 0;
		repeat (300) begin
			@(negedge sys_clk);
			if (update_pending_flag !== 1'b0) k++;
		end
		chk(k, 32'h0);
		$display("test converter off done");
		// write protect blocks even its own clearing
		xfer({1'b1, REG_CTRL}, 3'd1, 32'h40);
		xfer(8'h80, 3'd1, 32'hff);
		xfer(8'h00, 3'd1, 32'h0);
		chk({24'h0, rd[7:0]}, 32'h12);
		xfer({1'b1, REG_CTRL}, 3'd1, 32'h0);
		xfer({1'b0, REG_CTRL}, 3'd1, 32'h0);
		chk({24'h0, rd[7:0]}, 32'h40);
		$display("test write protect done");
		finish_test;
	end
	// hang guard, well past the expected run
	initial begin
		#(50 * 80000);
		failures++;
		finish_test;
	end
endmodule
